// file: rtl/breaker_failure_initiation_timing.sv
// Breaker failure initiation, contact interlock and delay timers with an AXI4-Lite slave.
`timescale 1ns/1ps
`default_nettype none
module breaker_failure_initiation_timing
    import bf_pkg::*;
(
    // Clock and reset.
    input  wire logic                  clock,
    input  wire logic                  reset,
    // Register bus.
    input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Internal feeder protection and current monitor, same clock.
    input  wire logic [2:0]            int_trip_phase,
    input  wire logic                  int_trip_no_current,
    input  wire logic [2:0]            current_flow,
    // External binary inputs.
    input  wire logic                  ext_start_phase_a_in,
    input  wire logic                  ext_start_phase_b_in,
    input  wire logic                  ext_start_phase_c_in,
    input  wire logic                  ext_start_three_phase_in,
    input  wire logic                  ext_start_no_current_in,
    input  wire logic                  start_release_in,
    input  wire logic                  supervision_block_in,
    // Breaker auxiliary contacts.
    input  wire logic [2:0]            pole_nc_closed_in,
    input  wire logic                  series_nc_closed_in,
    input  wire logic                  series_no_closed_in,
    // Trip outputs.
    output logic [2:0]                 retrip_phase,
    output logic                       backup_trip
);

    localparam int SYNC_W = 12;

    logic [SYNC_W-1:0]  pins_raw;
    logic [SYNC_W-1:0]  sync1_r;
    logic [SYNC_W-1:0]  sync2_r;
    logic [2:0]         ext_phase;
    logic               ext_three;
    logic               ext_nocur;
    logic               release_pin;
    logic               block_pin;
    logic [2:0]         nc_closed;
    logic               ser_nc_closed;
    logic               ser_no_closed;

    logic [CTRL_W-1:0]  ctrl_r;
    logic [DELAY_W-1:0] backup_delay_r;
    logic [DELAY_W-1:0] t1_sp_delay_r;
    logic [DELAY_W-1:0] t1_tp_delay_r;

    logic               contact_check_enable;
    logic               per_pole;
    logic               release_assigned;
    logic               segregated;
    logic               two_stage;
    logic               split_first;
    logic               retrip_single_pole_select;

    logic [2:0]         trip_p;
    logic               any_trip;
    logic               multi_trip;
    logic               all_phase_start;
    logic [2:0]         single_start;
    logic               released;
    logic               any_pole_closed;
    logic [2:0]         pole_closed;
    logic [2:0]         cur_seen_r;
    logic               cur_seen3_r;
    logic [2:0]         contact_p;
    logic               contact3;
    logic               nocur_start_r;
    logic [2:0]         init_p;
    logic               init3;
    logic [NUM_TIMERS-1:0]  tmr_run;
    logic [NUM_TIMERS-1:0]  tmr_exp;
    logic [DELAY_W-1:0]     tmr_lim [NUM_TIMERS];
    logic [2:0]         retrip_nxt;
    logic               backup_nxt;

    logic               aw_got_r;
    logic               w_got_r;
    logic [AXI_ADDR_W-1:0] aw_addr_r;
    logic [31:0]        w_data_r;
    logic [3:0]         w_strb_r;
    logic               wr_fire;
    logic [31:0]        status_word;
    logic [31:0]        rd_word;
    logic               rd_hit;
    logic               wr_hit;

    // Every binary input is asynchronous to the relay clock.
    assign pins_raw = {series_no_closed_in, series_nc_closed_in, pole_nc_closed_in,
                       supervision_block_in, start_release_in, ext_start_no_current_in,
                       ext_start_three_phase_in, ext_start_phase_c_in,
                       ext_start_phase_b_in, ext_start_phase_a_in};

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
        end
        else
        begin
            sync1_r <= pins_raw;
            sync2_r <= sync1_r;
        end
    end

    assign ext_phase     = sync2_r[2:0];
    assign ext_three     = sync2_r[3];
    assign ext_nocur     = sync2_r[4];
    assign release_pin   = sync2_r[5];
    assign block_pin     = sync2_r[6];
    assign nc_closed     = sync2_r[9:7];
    assign ser_nc_closed = sync2_r[10];
    assign ser_no_closed = sync2_r[11];

    assign contact_check_enable      = ctrl_r[CTRL_CHECK_BIT];
    assign per_pole                  = ctrl_r[CTRL_PERPOLE_BIT];
    assign release_assigned          = ctrl_r[CTRL_RELEASE_BIT];
    assign segregated                = ctrl_r[CTRL_SEGR_BIT];
    assign two_stage                 = ctrl_r[CTRL_TWOSTG_BIT];
    assign split_first               = ctrl_r[CTRL_SPLIT_BIT];
    assign retrip_single_pole_select = ctrl_r[CTRL_RETRIP1_BIT];

    // Closed NC contact means the pole is open.
    assign any_pole_closed = per_pole ? |(~nc_closed) : ~ser_nc_closed;
    assign pole_closed     = per_pole ? ~nc_closed : {3{ser_no_closed}};

    // Start decoding.
    assign trip_p          = int_trip_phase | ext_phase;
    assign any_trip        = |trip_p;
    assign multi_trip      = (trip_p[0] & trip_p[1]) | (trip_p[1] & trip_p[2])
                           | (trip_p[0] & trip_p[2]);
    assign all_phase_start = ext_three | multi_trip | (~segregated & any_trip);
    assign single_start    = (segregated & ~all_phase_start) ? trip_p : 3'h0;
    assign released        = ~release_assigned | release_pin;

    // Remember that current was seen during the trip, so a vanished current
    // wins over a slow or defective auxiliary contact.
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            cur_seen_r  <= 3'h0;
            cur_seen3_r <= 1'b0;
        end
        else
        begin
            cur_seen_r  <= trip_p & (cur_seen_r | current_flow);
            cur_seen3_r <= all_phase_start & (cur_seen3_r | (|current_flow));
        end
    end

    // Contacts count only while current is absent and was not seen.
    assign contact_p = {3{contact_check_enable}} & ~current_flow & ~cur_seen_r
                     & pole_closed;
    assign contact3  = contact_check_enable & ~(|current_flow) & ~cur_seen3_r
                     & any_pole_closed;

    // No-current start is held until contacts report the breaker open or the block input is set.
    always_ff @(posedge clock)
    begin
        if (reset)
            nocur_start_r <= 1'b0;
        else if (block_pin || !any_pole_closed)
            nocur_start_r <= 1'b0;
        else if ((int_trip_no_current || ext_nocur) && released)
            nocur_start_r <= 1'b1;
    end

    assign init3  = ~block_pin & released
                  & ((all_phase_start & ((|current_flow) | contact3))
                     | nocur_start_r);
    assign init_p = {3{~block_pin & released}} & single_start
                  & (current_flow | contact_p);

    // Timer 0: backup, 1: three-pole first stage, 2..4: single-pole first stages.
    assign tmr_run = {init_p, init3, init3 | (|init_p)};
    assign tmr_lim[0] = backup_delay_r;
    assign tmr_lim[1] = t1_tp_delay_r;
    assign tmr_lim[2] = t1_sp_delay_r;
    assign tmr_lim[3] = t1_sp_delay_r;
    assign tmr_lim[4] = t1_sp_delay_r;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_TIMERS; gi++)
        begin : g_tmr
            logic [DELAY_W-1:0] cnt_r;
            always_ff @(posedge clock)
            begin
                if (reset || !tmr_run[gi])
                    cnt_r <= '0;
                else if (cnt_r != tmr_lim[gi])
                    cnt_r <= cnt_r + 1'b1;
            end
            assign tmr_exp[gi] = tmr_run[gi] && (cnt_r == tmr_lim[gi]);
        end
    endgenerate

    // Output selection by stage configuration.
    always_comb
    begin
        retrip_nxt = 3'h0;
        backup_nxt = 1'b0;
        if (two_stage)
        begin
            if (tmr_exp[1])
                retrip_nxt = 3'h7;
            if (|tmr_exp[4:2])
                retrip_nxt = retrip_nxt
                           | (retrip_single_pole_select ? tmr_exp[4:2] : 3'h7);
            backup_nxt = tmr_exp[0];
        end
        else if (split_first)
            backup_nxt = |tmr_exp[4:1];
        else
            backup_nxt = tmr_exp[0];
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            retrip_phase <= 3'h0;
            backup_trip  <= 1'b0;
        end
        else
        begin
            retrip_phase <= retrip_nxt;
            backup_trip  <= backup_nxt;
        end
    end

    // AXI4-Lite write path: address and data taken in either order.
    assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_got_r & ~s_axi_bvalid;
    assign wr_fire       = aw_got_r & w_got_r & ~s_axi_bvalid;
    assign wr_hit        = (aw_addr_r == CTRL_OFFSET) || (aw_addr_r == BACKUP_OFFSET)
                        || (aw_addr_r == T1_SP_OFFSET) || (aw_addr_r == T1_TP_OFFSET);

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            aw_addr_r <= '0;
            w_data_r  <= 32'h0;
            w_strb_r  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_r  <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_got_r <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_r  <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            else if (wr_fire)
                w_got_r <= 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Settings; byte lanes honoured, bits above the field width ignored.
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            ctrl_r         <= CTRL_RESET;
            backup_delay_r <= BACKUP_RESET;
            t1_sp_delay_r  <= T1_SP_RESET;
            t1_tp_delay_r  <= T1_TP_RESET;
        end
        else if (wr_fire)
        begin
            for (int b = 0; b < 3; b++)
            begin
                if (w_strb_r[b])
                begin
                    if (aw_addr_r == BACKUP_OFFSET)
                        backup_delay_r[8*b +: 8] <= w_data_r[8*b +: 8];
                    if (aw_addr_r == T1_SP_OFFSET)
                        t1_sp_delay_r[8*b +: 8] <= w_data_r[8*b +: 8];
                    if (aw_addr_r == T1_TP_OFFSET)
                        t1_tp_delay_r[8*b +: 8] <= w_data_r[8*b +: 8];
                end
            end
            if (w_strb_r[0] && aw_addr_r == CTRL_OFFSET)
                ctrl_r <= w_data_r[CTRL_W-1:0];
        end
    end

    // AXI4-Lite read path: one cycle from address to data.
    assign status_word = {22'h0, backup_trip, retrip_phase, nocur_start_r, init_p,
                          init3, any_pole_closed};
    assign s_axi_arready = ~s_axi_rvalid;

    always_comb
    begin
        rd_hit  = 1'b1;
        rd_word = 32'h0;
        unique case (s_axi_araddr)
            CTRL_OFFSET:   rd_word = {25'h0, ctrl_r};
            BACKUP_OFFSET: rd_word = {8'h0, backup_delay_r};
            T1_SP_OFFSET:  rd_word = {8'h0, t1_sp_delay_r};
            T1_TP_OFFSET:  rd_word = {8'h0, t1_tp_delay_r};
            STATUS_OFFSET: rd_word = status_word;
            default:       rd_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

endmodule
`default_nettype wire

// file: rtl/bf_pkg.sv
// Constants, register map and reset values for breaker failure initiation and timing.
package bf_pkg;
    localparam int          CLOCK_HZ        = 10_000_000;
    localparam int          AXI_ADDR_W      = 8;
    localparam int          DELAY_W         = 24;

    localparam logic [7:0]  CTRL_OFFSET     = 8'h00;
    localparam logic [7:0]  BACKUP_OFFSET   = 8'h04;
    localparam logic [7:0]  T1_SP_OFFSET    = 8'h08;
    localparam logic [7:0]  T1_TP_OFFSET    = 8'h0c;
    localparam logic [7:0]  STATUS_OFFSET   = 8'h10;

    localparam int          CTRL_CHECK_BIT  = 0;
    localparam int          CTRL_PERPOLE_BIT = 1;
    localparam int          CTRL_RELEASE_BIT = 2;
    localparam int          CTRL_SEGR_BIT   = 3;
    localparam int          CTRL_TWOSTG_BIT = 4;
    localparam int          CTRL_SPLIT_BIT  = 5;
    localparam int          CTRL_RETRIP1_BIT = 6;
    localparam int          CTRL_W          = 7;

    localparam logic [6:0]  CTRL_RESET      = 7'h03;
    localparam logic [23:0] BACKUP_RESET    = 24'h000800;
    localparam logic [23:0] T1_SP_RESET     = 24'h000400;
    localparam logic [23:0] T1_TP_RESET     = 24'h000400;

    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    localparam int          NUM_TIMERS      = 5;
endpackage

// file: verification/bf_properties.sv
// Assertions on the register bus and trip outputs of the breaker failure block.
`timescale 1ns/1ps
`default_nettype none
module bf_properties
    import bf_pkg::*;
(
    // Clock and reset.
    input wire logic                  clock,
    input wire logic                  reset,
    // Register bus.
    input wire logic                  s_axi_awvalid,
    input wire logic                  s_axi_awready,
    input wire logic                  s_axi_wvalid,
    input wire logic                  s_axi_wready,
    input wire logic [1:0]            s_axi_bresp,
    input wire logic                  s_axi_bvalid,
    input wire logic                  s_axi_bready,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic [31:0]           s_axi_rdata,
    input wire logic [1:0]            s_axi_rresp,
    input wire logic                  s_axi_rvalid,
    input wire logic                  s_axi_rready,
    // Block input and trip outputs.
    input wire logic                  supervision_block_in,
    input wire logic [2:0]            retrip_phase,
    input wire logic                  backup_trip
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    // Six cycles cover the input synchroniser, the timer clear and the output register.
    a_block_quiet: assert property (supervision_block_in [*6] |->
        retrip_phase == 3'h0 && !backup_trip) else $error("trip output while blocked");
    a_reset_quiet: assert property ($fell(reset) |-> !backup_trip && retrip_phase == 3'h0
        && !s_axi_bvalid && !s_axi_rvalid) else $error("output active after reset");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
    a_read_unmapped: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr[1:0] == 2'h0 && s_axi_araddr > STATUS_OFFSET |=> s_axi_rvalid
        && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_read_mapped: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr[1:0] == 2'h0 && s_axi_araddr <= STATUS_OFFSET |=> s_axi_rvalid
        && s_axi_rresp == RESP_OKAY) else $error("mapped read refused");
endmodule

bind breaker_failure_initiation_timing bf_properties bf_properties_inst (
    .clock(clock), .reset(reset),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .supervision_block_in(supervision_block_in), .retrip_phase(retrip_phase),
    .backup_trip(backup_trip));
`default_nettype wire

// file: verification/breaker_model.sv
// Breaker model with three poles, lagging auxiliary contacts and fault current.
`timescale 1ns/1ps
`default_nettype none
module breaker_model #(
    parameter int OPEN_DELAY  = 3,
    parameter int CONTACT_LAG = 60
) (
    // Bench control.
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic [2:0] open_req,
    input  wire logic       stuck,
    input  wire logic       fault,
    input  wire logic       reclose,
    // Breaker side.
    output logic [2:0]      current_flow,
    output logic [2:0]      pole_nc_closed_in,
    output logic            series_nc_closed_in,
    output logic            series_no_closed_in
);
    logic [2:0] closed_r;
    logic [2:0] contact_r;
    int         open_cnt_r;
    int         lag_cnt_r;
    always_ff @(posedge clock)
    begin
        if (reset || reclose || open_req == 3'h0)
            open_cnt_r <= 0;
        else if (open_cnt_r < OPEN_DELAY)
            open_cnt_r <= open_cnt_r + 1;
        if (reset || reclose)
            closed_r <= 3'h7;
        else if (open_cnt_r == OPEN_DELAY && !stuck)
            closed_r <= closed_r & ~open_req;
    end
    // Contacts trail the poles, so a design that trusts them over current trips after the breaker has opened.
    always_ff @(posedge clock)
    begin
        if (reset || reclose || contact_r == closed_r)
            lag_cnt_r <= 0;
        else
            lag_cnt_r <= lag_cnt_r + 1;
        if (reset || reclose)
            contact_r <= 3'h7;
        else if (lag_cnt_r >= CONTACT_LAG)
            contact_r <= closed_r;
    end
    assign current_flow        = closed_r & {3{fault}};
    assign pole_nc_closed_in   = ~contact_r;
    assign series_nc_closed_in = &(~contact_r);
    assign series_no_closed_in = &contact_r;
endmodule
`default_nettype wire

// file: verification/breaker_failure_initiation_timing_tb.sv
// Self-checking bench for the breaker failure block.
`timescale 1ns/1ps
`default_nettype none
module breaker_failure_initiation_timing_tb;
    import bf_pkg::*;
    logic        clock, reset, aw_v, w_v, b_rdy, ar_v, r_rdy, aw_r, w_r, b_v, ar_r, r_v, int_nc;
    logic [7:0]  aw_a, ar_a;
    logic [31:0] w_d, r_d;
    logic [1:0]  b_s, r_s;
    logic [2:0]  trip, open_req, cur, pole_nc, retrip;
    logic        ext_a, ext_3p, ext_nc, rel, blk, stuck, fault, reclose, ser_nc, ser_no, backup;
    int          fail_count, compares;
    logic [7:0]  ra [5] = '{CTRL_OFFSET, BACKUP_OFFSET, T1_SP_OFFSET, T1_TP_OFFSET, STATUS_OFFSET};
    logic [31:0] rv [5] = '{{25'h0, CTRL_RESET}, {8'h0, BACKUP_RESET}, {8'h0, T1_SP_RESET},
                            {8'h0, T1_TP_RESET}, 32'h1};
    logic [7:0]  t_ctrl [5] = '{8'h5b, 8'h1b, 8'h5b, 8'h5b, 8'h2b};
    logic [2:0]  t_trip [5] = '{3'h1, 3'h1, 3'h3, 3'h1, 3'h1};
    logic        t_stuck [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    logic [3:0]  t_exp1 [5] = '{4'h2, 4'he, 4'he, 4'h0, 4'h1};
    logic [3:0]  t_exp2 [5] = '{4'h3, 4'hf, 4'hf, 4'h0, 4'h1};

    breaker_failure_initiation_timing breaker_failure_initiation_timing_inst (
        .clock(clock), .reset(reset), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
        .s_axi_awready(aw_r), .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v),
        .s_axi_wready(w_r), .s_axi_bresp(b_s), .s_axi_bvalid(b_v), .s_axi_bready(b_rdy),
        .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_rdata(r_d),
        .s_axi_rresp(r_s), .s_axi_rvalid(r_v), .s_axi_rready(r_rdy), .int_trip_phase(trip),
        .int_trip_no_current(int_nc), .current_flow(cur), .ext_start_phase_a_in(ext_a),
        .ext_start_phase_b_in(1'b0), .ext_start_phase_c_in(1'b0),
        .ext_start_three_phase_in(ext_3p), .ext_start_no_current_in(ext_nc),
        .start_release_in(rel), .supervision_block_in(blk), .pole_nc_closed_in(pole_nc),
        .series_nc_closed_in(ser_nc), .series_no_closed_in(ser_no), .retrip_phase(retrip),
        .backup_trip(backup));
    breaker_model breaker_model_inst (
        .clock(clock), .reset(reset), .open_req(open_req), .stuck(stuck), .fault(fault),
        .reclose(reclose), .current_flow(cur), .pole_nc_closed_in(pole_nc),
        .series_nc_closed_in(ser_nc), .series_no_closed_in(ser_no));

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic test_done();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Ready is sampled mid-cycle, where it is settled, and acted on at the next rising edge.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic a_hs, d_hs, b_hs;
        logic [1:0] s;
        @(posedge clock);
        {aw_a, w_d, aw_v, w_v, b_rdy} <= {a, d, 3'h7};
        for (int n = 0; n < 50; n++)
        begin
            @(negedge clock);
            {a_hs, d_hs, b_hs, s} = {aw_v && aw_r, w_v && w_r, b_v, b_s};
            @(posedge clock);
            if (a_hs) aw_v <= 1'b0;
            if (d_hs) w_v <= 1'b0;
            if (b_hs)
            begin
                b_rdy <= 1'b0;
                chk("write response", {30'h0, er}, {30'h0, s});
                return;
            end
        end
        fail_count++;
        test_done();
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic a_hs, r_hs;
        logic [33:0] got;
        @(posedge clock);
        {ar_a, ar_v, r_rdy} <= {a, 2'h3};
        for (int n = 0; n < 50; n++)
        begin
            @(negedge clock);
            {a_hs, r_hs, got} = {ar_v && ar_r, r_v, r_s, r_d};
            @(posedge clock);
            if (a_hs) ar_v <= 1'b0;
            if (r_hs)
            begin
                r_rdy <= 1'b0;
                chk("read data", ed, got[31:0]);
                chk("read response", {30'h0, er}, {30'h0, got[33:32]});
                return;
            end
        end
        fail_count++;
        test_done();
    endtask

    task automatic expect_out(input int cycles, input logic [3:0] exp);
        repeat (cycles) @(posedge clock);
        @(negedge clock);
        chk("retrip and backup", {28'h0, exp}, {28'h0, retrip, backup});
    endtask

    task automatic apply(input logic [2:0] t, input logic [2:0] o, input logic s, input logic f);
        @(posedge clock);
        {trip, open_req, stuck, fault} <= {t, o, s, f};
    endtask

    task automatic settle(input string name);
        @(posedge clock);
        {trip, open_req, stuck, fault, ext_3p, ext_nc, rel, blk, reclose} <= 13'h1;
        @(posedge clock);
        reclose <= 1'b0;
        repeat (8) @(posedge clock);
        $display("test %s done", name);
    endtask

    initial
    begin
        {reset, aw_v, w_v, b_rdy, ar_v, r_rdy, aw_a, ar_a, w_d} <= {6'h20, 48'h0};
        {trip, open_req, stuck, fault, ext_a, ext_3p, ext_nc, rel, blk, reclose, int_nc} <= 15'h0;
        {fail_count, compares} = 64'h0;
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        foreach (ra[i]) axi_read(ra[i], rv[i], RESP_OKAY);
        axi_read(8'h20, 32'h0, RESP_SLVERR);
        axi_write(8'h20, 32'hffff_ffff, RESP_SLVERR);
        axi_write(BACKUP_OFFSET, 32'd40, RESP_OKAY);
        axi_write(T1_SP_OFFSET, 32'd15, RESP_OKAY);
        axi_write(T1_TP_OFFSET, 32'd15, RESP_OKAY);
        axi_read(T1_TP_OFFSET, 32'd15, RESP_OKAY);
        $display("test registers done");
        axi_write(CTRL_OFFSET, 32'h3, RESP_OKAY);
        blk <= 1'b1;
        ext_3p <= 1'b1;
        apply(3'h0, 3'h7, 1'b1, 1'b1);
        expect_out(60, 4'h0);
        blk <= 1'b0;
        expect_out(30, 4'h0);
        expect_out(20, 4'h1);
        ext_3p <= 1'b0;
        expect_out(6, 4'h0);
        settle("common");
        apply(3'h7, 3'h7, 1'b0, 1'b1);
        expect_out(55, 4'h0);
        settle("interlock");
        axi_write(CTRL_OFFSET, 32'h7, RESP_OKAY);
        ext_3p <= 1'b1;
        apply(3'h0, 3'h7, 1'b1, 1'b1);
        expect_out(60, 4'h0);
        rel <= 1'b1;
        expect_out(50, 4'h1);
        settle("release");
        axi_write(CTRL_OFFSET, 32'h2, RESP_OKAY);
        apply(3'h7, 3'h7, 1'b1, 1'b0);
        expect_out(60, 4'h0);
        axi_write(CTRL_OFFSET, 32'h3, RESP_OKAY);
        expect_out(55, 4'h1);
        settle("contacts");
        axi_write(CTRL_OFFSET, 32'hb, RESP_OKAY);
        ext_nc <= 1'b1;
        repeat (5) @(posedge clock);
        ext_nc <= 1'b0;
        expect_out(55, 4'h1);
        apply(3'h0, 3'h7, 1'b0, 1'b0);
        expect_out(75, 4'h0);
        settle("no current");
        int_nc <= 1'b1;
        repeat (5) @(posedge clock);
        int_nc <= 1'b0;
        expect_out(55, 4'h1);
        blk <= 1'b1;
        expect_out(5, 4'h0);
        settle("internal no current");
        for (int i = 0; i < 5; i++)
        begin
            axi_write(CTRL_OFFSET, {24'h0, t_ctrl[i]}, RESP_OKAY);
            apply(t_trip[i], t_trip[i], t_stuck[i], 1'b1);
            expect_out(10, 4'h0);
            expect_out(15, t_exp1[i]);
            expect_out(25, t_exp2[i]);
            settle("stages");
        end
        test_done();
    end
endmodule
`default_nettype wire
